/* regulator_channel_config_regs.sv */
// Channel enable, voltage code and voltage scaling registers of the regulator
`timescale 1ns/1ps
`include "regulator_cfg_params.svh"

// Operation
// - Channel runs only when its soft enable bit and hardware pin both are high.
// - Soft enable bits reset to 1, so pins alone decide after reset.
// - Soft enable writes affect a channel only while its pin is high.
// - A low pin forces its soft enable bit back to 1.
// - Enable bits 0..4 are channels 1..5; bits 7:5 reserved.
// - Channel 1 code is bits 4:0 of its register; 0 means adjustable.
// - Channel 3 code is bits 6:4 of shared register; 0 means adjustable.
// - Channel 2 code is bits 2:0 of shared register; 0 means adjustable.
// - Channel 4 code is bits 4:0 of its register; 0 means adjustable.
// - Voltage code reset values come from factory fuse inputs.
// - Bit 6 enables channel 4 scaling; resets to 0.
// - Bit 2 enables channel 1 scaling; resets to 0.
// - Bits 5:4 pick channel 4 step interval 62.5/31.2/15.6/7.8 us.
// - Bits 1:0 pick channel 1 step interval, same encoding.
// - Registers return to reset values only on the power-on reset.
module regulator_channel_config_regs
  import regulator_cfg_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire reg_req_type                req_i,
  output logic      [7:0]                 rdata_o,
  output logic                            rvalid_o,
  input  wire logic [`NUM_CHANNELS-1:0]   chan_hw_enable_pin_i,
  input  wire fuse_codes_type             fuse_codes_i,
  output logic      [`NUM_CHANNELS-1:0]   chan_enable_o,
  output applied_codes_type               applied_codes_o
);

  // ****************************************************************
  // Behaviour seen from outside
  // ****************************************************************
  // Register port: a write lands on the edge that takes it; a read answers
  // with rvalid_o one cycle later, and rdata_o holds until the next read.
  // A read and a write in the same cycle are both taken; the read shows
  // the old contents. Unmapped offsets ignore writes and read as zero.
  // All eight bits of each register are stored and read back; reserved
  // bits drive nothing.
  // Enable pins pass two synchroniser stages and the output flop, so a pin
  // change reaches chan_enable_o three cycles later; pulses shorter than a
  // cycle may be missed, which is fine for slow enable levels.
  // A low pin beats a same-cycle write that clears the channel's bit.
  // Fuse codes are sampled once, on the first edge after reset release;
  // a write to a code register on that very edge is lost.
  // Step intervals become 625, 312, 156 or 78 cycles, rounded down; the
  // stepper adds two cycles of overhead to each step.
  // Clearing a scaling enable mid-ramp lets the applied code jump to target.

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [`NUM_CHANNELS-1:0] pin_meta_q;
  logic [`NUM_CHANNELS-1:0] pin_sync_q;

  // Enable pins are asynchronous to clk_i, two stages before use
  // Reset low keeps every channel off until its pin has been seen
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= chan_hw_enable_pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************************************
  // Fuse capture
  // ****************************************************************
  // Fuses are caught by a clocked process after reset release, never
  // loaded into the flops under the asynchronous reset itself.
  // Holding the load for a single cycle keeps later writes from being undone.
  logic fuse_load_q;
  logic fuse_load_d;

  assign fuse_load_d = 1'b0;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      fuse_load_q <= 1'b1;
    else
      fuse_load_q <= fuse_load_d;
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] enable_ctrl_q;
  logic [7:0] enable_ctrl_d;
  logic [7:0] ch1_code_q;
  logic [7:0] ch1_code_d;
  logic [7:0] ch23_code_q;
  logic [7:0] ch23_code_d;
  logic [7:0] ch4_code_q;
  logic [7:0] ch4_code_d;
  logic [7:0] scaling_cfg_q;
  logic [7:0] scaling_cfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  // Address match helper used by every write strobe
  function automatic logic hit(input reg_req_type r, input logic [7:0] ofs);
    hit = (r.addr == ofs);
  endfunction

  // ****************************************************************
  // Write decode
  // ****************************************************************
  logic wr_enable_ctrl;
  logic wr_ch1_code;
  logic wr_ch23_code;
  logic wr_ch4_code;
  logic wr_scaling_cfg;

  // One strobe per register; offsets compare exactly, so nothing aliases
  always_comb
  begin
    wr_enable_ctrl = req_i.wr_en && hit(req_i, `OFS_CHANNEL_ENABLE_CTRL);
    wr_ch1_code    = req_i.wr_en && hit(req_i, `OFS_CH1_VOLTAGE_CODE);
    wr_ch23_code   = req_i.wr_en && hit(req_i, `OFS_CH2_CH3_VOLTAGE);
    wr_ch4_code    = req_i.wr_en && hit(req_i, `OFS_CH4_VOLTAGE_CODE);
    wr_scaling_cfg = req_i.wr_en && hit(req_i, `OFS_VOLTAGE_SCALING_CFG);
  end

  // Next values for writes, pin forcing and fuse loading
  always_comb
  begin
    enable_ctrl_d = enable_ctrl_q;
    ch1_code_d    = ch1_code_q;
    ch23_code_d   = ch23_code_q;
    ch4_code_d    = ch4_code_q;
    scaling_cfg_d = scaling_cfg_q;
    if (wr_enable_ctrl)
      enable_ctrl_d = req_i.wdata;
    if (wr_ch1_code)
      ch1_code_d = req_i.wdata;
    if (wr_ch23_code)
      ch23_code_d = req_i.wdata;
    if (wr_ch4_code)
      ch4_code_d = req_i.wdata;
    if (wr_scaling_cfg)
      scaling_cfg_d = req_i.wdata;
    // Pin low wins over a same-cycle write, so startup is always clean
    for (int i = 0; i < `NUM_CHANNELS; i++)
    begin
      if (!pin_sync_q[i])
      begin
        enable_ctrl_d[i] = 1'b1;
      end
    end
    // Fuse defaults on the first cycle after reset, reserved bits zero
    if (fuse_load_q)
    begin
      ch1_code_d  = {3'h0, fuse_codes_i.chan1_voltage_code};
      ch23_code_d = {1'b0, fuse_codes_i.chan3_voltage_code, 1'b0,
                     fuse_codes_i.chan2_voltage_code};
      ch4_code_d  = {3'h0, fuse_codes_i.chan4_voltage_code};
    end
  end

  // Only the power-on reset clears the bank
  // Code registers clear to zero here; the fuse load fills them one edge later
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      enable_ctrl_q <= `RST_CHANNEL_ENABLE_CTRL;
      ch1_code_q    <= 8'h00;
      ch23_code_q   <= 8'h00;
      ch4_code_q    <= 8'h00;
      scaling_cfg_q <= `RST_VOLTAGE_SCALING_CFG;
    end
    else
    begin
      enable_ctrl_q <= enable_ctrl_d;
      ch1_code_q    <= ch1_code_d;
      ch23_code_q   <= ch23_code_d;
      ch4_code_q    <= ch4_code_d;
      scaling_cfg_q <= scaling_cfg_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped offsets read as zero; rdata_q keeps its value between reads
  always_comb
  begin
    rvalid_d = req_i.rd_en;
    rdata_d  = rdata_q;
    if (req_i.rd_en)
    begin
      case (req_i.addr)
        `OFS_CHANNEL_ENABLE_CTRL: rdata_d = enable_ctrl_q;
        `OFS_CH1_VOLTAGE_CODE:    rdata_d = ch1_code_q;
        `OFS_CH2_CH3_VOLTAGE:     rdata_d = ch23_code_q;
        `OFS_CH4_VOLTAGE_CODE:    rdata_d = ch4_code_q;
        `OFS_VOLTAGE_SCALING_CFG: rdata_d = scaling_cfg_q;
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  // Answer registers; rvalid_q pulses for one cycle per read
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata_o  = rdata_q;
  assign rvalid_o = rvalid_q;

  // ****************************************************************
  // Channel enables
  // ****************************************************************
  logic [`NUM_CHANNELS-1:0] chan_enable_q;
  logic [`NUM_CHANNELS-1:0] chan_enable_d;

  // Soft bit ANDed with the synchronised pin; registered for a clean output
  always_comb
  begin
    chan_enable_d = enable_ctrl_q[`NUM_CHANNELS-1:0] & pin_sync_q;
  end

  // Enables start off and rise only once the synchronised pins are seen
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      chan_enable_q <= '0;
    else
      chan_enable_q <= chan_enable_d;
  end

  assign chan_enable_o = chan_enable_q;

  // ****************************************************************
  // Applied voltage codes
  // ****************************************************************
  logic [4:0] ch1_applied;
  logic [4:0] ch4_applied;

  // Channel 1 ramps when its scaling bit is set
  voltage_ramp #(
    .CODE_W (5)
  ) ch1_ramp (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .load_i      (fuse_load_q),
    .load_code_i (fuse_codes_i.chan1_voltage_code),
    .target_i    (ch1_code_q[4:0]),
    .scale_en_i  (scaling_cfg_q[`CH1_SCALE_EN_BIT]),
    .interval_i  (scaling_cfg_q[`CH1_SCALE_INT_LSB +: 2]),
    .applied_o   (ch1_applied)
  );

  // Channel 4 ramps when its scaling bit is set
  voltage_ramp #(
    .CODE_W (5)
  ) ch4_ramp (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .load_i      (fuse_load_q),
    .load_code_i (fuse_codes_i.chan4_voltage_code),
    .target_i    (ch4_code_q[4:0]),
    .scale_en_i  (scaling_cfg_q[`CH4_SCALE_EN_BIT]),
    .interval_i  (scaling_cfg_q[`CH4_SCALE_INT_LSB +: 2]),
    .applied_o   (ch4_applied)
  );

  // Channels 2 and 3 have no scaling and follow their fields directly.
  // One process drives the whole struct, so every field has a single driver
  // and no field can be left floating.
  always_comb
  begin
    applied_codes_o.chan1_voltage_code = ch1_applied;
    applied_codes_o.chan2_voltage_code = ch23_code_q[`CH2_CODE_LSB +: 3];
    applied_codes_o.chan3_voltage_code = ch23_code_q[`CH3_CODE_LSB +: 3];
    applied_codes_o.chan4_voltage_code = ch4_applied;
  end

endmodule

/* regulator_cfg_params.svh */
// Offsets, field positions, reset values and timing counts of the regulator configuration bank
`ifndef REGULATOR_CFG_PARAMS_SVH
`define REGULATOR_CFG_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_CHANNEL_ENABLE_CTRL 8'h01
`define OFS_CH1_VOLTAGE_CODE    8'h02
`define OFS_CH2_CH3_VOLTAGE     8'h03
`define OFS_CH4_VOLTAGE_CODE    8'h04
`define OFS_VOLTAGE_SCALING_CFG 8'h05

// ****************************************************************
// Field positions
// ****************************************************************
`define NUM_CHANNELS            5
`define CH3_CODE_LSB            4
`define CH2_CODE_LSB            0
`define CH4_SCALE_EN_BIT        6
`define CH4_SCALE_INT_LSB       4
`define CH1_SCALE_EN_BIT        2
`define CH1_SCALE_INT_LSB       0

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CHANNEL_ENABLE_CTRL 8'h1F
`define RST_VOLTAGE_SCALING_CFG 8'h00

// ****************************************************************
// Step intervals in ns and their cycle counts at 100 ns per cycle
// ****************************************************************
`define CLK_PERIOD_NS           100
`define STEP_62US5_NS           62500
`define STEP_31US2_NS           31200
`define STEP_15US6_NS           15600
`define STEP_7US8_NS            7800
`define STEP_62US5_CYC          (`STEP_62US5_NS / `CLK_PERIOD_NS)
`define STEP_31US2_CYC          (`STEP_31US2_NS / `CLK_PERIOD_NS)
`define STEP_15US6_CYC          (`STEP_15US6_NS / `CLK_PERIOD_NS)
`define STEP_7US8_CYC           (`STEP_7US8_NS / `CLK_PERIOD_NS)

`endif

/* regulator_cfg_pkg.sv */
// Types shared by the regulator configuration bank
package regulator_cfg_pkg;

  // Register access from the serial front end
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Factory fuse defaults for the voltage codes
  typedef struct packed {
    logic [4:0] chan1_voltage_code;
    logic [2:0] chan2_voltage_code;
    logic [2:0] chan3_voltage_code;
    logic [4:0] chan4_voltage_code;
  } fuse_codes_type;

  // Codes applied to the regulators
  typedef struct packed {
    logic [4:0] chan1_voltage_code;
    logic [2:0] chan2_voltage_code;
    logic [2:0] chan3_voltage_code;
    logic [4:0] chan4_voltage_code;
  } applied_codes_type;

  typedef enum logic [1:0] {
    SCALE_IDLE,
    SCALE_WAIT,
    SCALE_STEP
  } scale_state_type;

endpackage

/* voltage_ramp.sv */
// One channel's voltage scaling stepper: walks the applied code toward the target
`timescale 1ns/1ps
`include "regulator_cfg_params.svh"

module voltage_ramp
  import regulator_cfg_pkg::*;
#(
  parameter int CODE_W = 5
)
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              load_i,
  input  wire logic [CODE_W-1:0] load_code_i,
  input  wire logic [CODE_W-1:0] target_i,
  input  wire logic              scale_en_i,
  input  wire logic [1:0]        interval_i,
  output logic      [CODE_W-1:0] applied_o
);

  // ****************************************************************
  // Interval decode
  // ****************************************************************
  function automatic logic [9:0] interval_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    interval_cycles = 10'(`STEP_62US5_CYC);
      2'h1:    interval_cycles = 10'(`STEP_31US2_CYC);
      2'h2:    interval_cycles = 10'(`STEP_15US6_CYC);
      default: interval_cycles = 10'(`STEP_7US8_CYC);
    endcase
  endfunction

  scale_state_type   state_q;
  scale_state_type   state_d;
  logic [9:0]        count_q;
  logic [9:0]        count_d;
  logic [CODE_W-1:0] applied_q;
  logic [CODE_W-1:0] applied_d;

  // ****************************************************************
  // Next state: step once per interval, jump when scaling is off
  // ****************************************************************
  always_comb
  begin
    state_d   = state_q;
    count_d   = count_q;
    applied_d = applied_q;
    if (load_i)
    begin
      applied_d = load_code_i;
      state_d   = SCALE_IDLE;
    end
    else if (!scale_en_i)
    begin
      applied_d = target_i;
      state_d   = SCALE_IDLE;
    end
    else
    begin
      case (state_q)
        SCALE_IDLE:
        begin
          if (applied_q != target_i)
          begin
            count_d = interval_cycles(interval_i) - 10'h001;
            state_d = SCALE_WAIT;
          end
        end
        SCALE_WAIT:
        begin
          if (count_q == 10'h000)
            state_d = SCALE_STEP;
          else
            count_d = count_q - 10'h001;
        end
        SCALE_STEP:
        begin
          // One code step toward the target, never past it
          if (applied_q < target_i)
            applied_d = applied_q + CODE_W'(1);
          else if (applied_q > target_i)
            applied_d = applied_q - CODE_W'(1);
          state_d = SCALE_IDLE;
        end
        default: state_d = SCALE_IDLE;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q   <= SCALE_IDLE;
      count_q   <= 10'h000;
      applied_q <= '0;
    end
    else
    begin
      state_q   <= state_d;
      count_q   <= count_d;
      applied_q <= applied_d;
    end
  end

  assign applied_o = applied_q;

endmodule

/* regulator_cfg_chk.sv */
// Port assertions of the regulator configuration bank
`timescale 1ns/1ps

module regulator_cfg_chk
  import regulator_cfg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire reg_req_type       req_i,
  input  wire logic [7:0]        rdata_o,
  input  wire logic              rvalid_o,
  input  wire logic [4:0]        chan_hw_enable_pin_i,
  input  wire fuse_codes_type    fuse_codes_i,
  input  wire logic [4:0]        chan_enable_o,
  input  wire applied_codes_type applied_codes_o
);
  // ********
  // Helper state
  // ********
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [4:0] prev4_q;
  logic [4:0] prev4_d;
  logic [9:0] gap_q;
  logic [9:0] gap_d;
  logic       wr2;
  logic       wr3;
  logic       wr4;
  logic       step4;

  // Write decode and channel 4 step detect
  assign wr2   = req_i.wr_en && req_i.addr == 8'h02;
  assign wr3   = req_i.wr_en && req_i.addr == 8'h03;
  assign wr4   = req_i.wr_en && req_i.addr == 8'h04;
  assign step4 = applied_codes_o.chan4_voltage_code != prev4_q;

  // Shadow of the scaling register; gap saturates so long idle stretches do not wrap
  always_comb
  begin
    cfg_d   = (req_i.wr_en && req_i.addr == 8'h05) ? req_i.wdata : cfg_q;
    prev4_d = applied_codes_o.chan4_voltage_code;
    gap_d   = (step4 || wr4) ? 10'h000 : ((gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001);
  end

  // Helper registers
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg_q   <= 8'h00;
      prev4_q <= 5'h00;
      gap_q   <= 10'h000;
    end
    else
    begin
      cfg_q   <= cfg_d;
      prev4_q <= prev4_d;
      gap_q   <= gap_d;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ********
  // Assertions
  // ********
  a_read_answer: assert property (req_i.rd_en |=> rvalid_o)
    else $error("read without answer");
  a_rvalid_cause: assert property (rvalid_o |-> $past(req_i.rd_en))
    else $error("answer without read");
  a_enable_needs_pin: assert property (
    (chan_enable_o & ~($past(chan_hw_enable_pin_i, 2) | $past(chan_hw_enable_pin_i, 3)
      | $past(chan_hw_enable_pin_i, 4))) == 5'h00)
    else $error("channel on with pin low");
  a_reset_enables: assert property ($fell(sys_rst_i) && &chan_hw_enable_pin_i |->
    ##[2:5] chan_enable_o == 5'h1F)
    else $error("channels not on after reset");
  a_shared_codes: assert property (wr3 |-> ##2
    {applied_codes_o.chan3_voltage_code, applied_codes_o.chan2_voltage_code}
      == {$past(req_i.wdata[6:4], 2), $past(req_i.wdata[2:0], 2)})
    else $error("channel 2 or 3 code wrong");
  a_ch1_direct: assert property (wr2 && !cfg_q[2] |-> ##3
    applied_codes_o.chan1_voltage_code == $past(req_i.wdata[4:0], 3))
    else $error("channel 1 code wrong");
  a_ch4_direct: assert property (wr4 && !cfg_q[6] |-> ##3
    applied_codes_o.chan4_voltage_code == $past(req_i.wdata[4:0], 3))
    else $error("channel 4 code wrong");
  a_single_step: assert property (cfg_q[6] && $past(cfg_q[6]) && step4 |->
    applied_codes_o.chan4_voltage_code == prev4_q + 5'h01
      || applied_codes_o.chan4_voltage_code == prev4_q - 5'h01)
    else $error("channel 4 ramp jumped");
  a_step_spacing: assert property (cfg_q[6] && cfg_q[5:4] == 2'b11 && step4 |->
    gap_q >= 10'h04A && gap_q <= 10'h056)
    else $error("channel 4 step interval wrong");

  // Main scenarios reached
  c_ramp_step: cover property (cfg_q[6] && step4);
  c_pin_drop: cover property ($fell(chan_hw_enable_pin_i[1]));
  c_unmapped: cover property (req_i.rd_en && req_i.addr == 8'h06);
endmodule

bind regulator_channel_config_regs regulator_cfg_chk chk_i (
  .clk_i                (clk_i),
  .sys_rst_i            (sys_rst_i),
  .req_i                (req_i),
  .rdata_o              (rdata_o),
  .rvalid_o             (rvalid_o),
  .chan_hw_enable_pin_i (chan_hw_enable_pin_i),
  .fuse_codes_i         (fuse_codes_i),
  .chan_enable_o        (chan_enable_o),
  .applied_codes_o      (applied_codes_o)
);

/* cfg_host_model.sv */
// Serial host model issuing register writes and reads to the bank
`timescale 1ns/1ps

module cfg_host_model
  import regulator_cfg_pkg::*;
(
  input  wire logic       clk_i,
  output reg_req_type     req_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  // Idle cycles before each request; nonzero makes a slow host
  int idle = 0;

  // Bus idle at start
  initial
  begin
    req_o = '0;
  end

  // One write; released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (idle) @(posedge clk_i);
    @(posedge clk_i);
    #1;
    req_o = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    req_o = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One read; data taken in the answer cycle or returned unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat (idle) @(posedge clk_i);
    @(posedge clk_i);
    #1;
    req_o = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    #1;
    req_o = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 8'hFF};
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask
endmodule

/* tb_top.sv */
// Self-checking testbench of the regulator configuration bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module tb_top
  import regulator_cfg_pkg::*;
;
  logic              clk_i      = 1'b0;
  logic              sys_rst_i  = 1'b1;
  reg_req_type       req;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [4:0]        pins       = 5'h1F;
  fuse_codes_type    fuse       = {5'h0A, 3'h5, 3'h2, 5'h06};
  logic [4:0]        chan_en;
  applied_codes_type ac;
  int                n_mismatch = 0;
  int                checks     = 0;
  int                cyc        = 0;
  logic [7:0]        d;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  regulator_channel_config_regs uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .chan_hw_enable_pin_i(pins), .fuse_codes_i(fuse), .chan_enable_o(chan_en),
    .applied_codes_o(ac));
  cfg_host_model host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // ********
  // Helpers
  // ********
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reset for two cycles, then let the fuse load edge pass
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [4:0] code(input logic [7:0] a);
    return (a == 8'h02) ? ac.chan1_voltage_code : ac.chan4_voltage_code;
  endfunction

  // ********
  // Scenarios
  // ********
  // Reset contents of every register, unmapped offsets 0 and 6 included
  task automatic t_reset_vals();
    logic [7:0] exp [7];
    exp = '{8'h00, 8'h1F, {3'h0, fuse.chan1_voltage_code},
      {1'b0, fuse.chan3_voltage_code, 1'b0, fuse.chan2_voltage_code}, {3'h0, fuse.chan4_voltage_code}, 8'h00, 8'h00};
    for (int a = 0; a < 7; a++)
    begin
      host.rd(8'(a), d);
      `CHK("reset read", exp[a], d)
    end
    `CHK("reset codes", 16'(fuse), 16'(ac))
    `CHK("reset enables", 5'h1F, chan_en)
  endtask

  // Full byte writes with a slow host, reserved bits kept, unmapped write ignored
  task automatic t_rw_all();
    logic [7:0] pat [1:5];
    pat = '{8'hE5, 8'hB3, 8'hD5, 8'hE4, 8'h88};
    host.idle = 2;
    for (int a = 1; a < 6; a++)
      host.wr(8'(a), pat[a]);
    host.wr(8'h06, 8'hFF);
    host.idle = 0;
    for (int a = 1; a < 7; a++)
    begin
      host.rd(8'(a), d);
      `CHK("read back", (a < 6) ? pat[a] : 8'h00, d)
    end
    `CHK("field codes", {5'h13, 3'h5, 3'h5, 5'h04}, 16'(ac))
    `CHK("soft enables", 5'h05, chan_en)
  endtask

  // Pin low forces its bit to 1 and overrides writes; pin return restarts the channel
  task automatic t_pins();
    @(posedge clk_i);
    #1;
    pins[1] = 1'b0;
    repeat (5) @(posedge clk_i);
    host.rd(8'h01, d);
    `CHK("forced bit", 8'hE7, d)
    host.wr(8'h01, 8'hE0);
    host.rd(8'h01, d);
    `CHK("pin wins", 8'hE2, d)
    `CHK("enables off", 5'h00, chan_en)
    pins[1] = 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK("restart", 5'h02, chan_en)
    pins = 5'h1F;
  endtask

  // Scaling on: one code per interval toward the target
  task automatic t_ramp(input logic [7:0] cfg, input logic [7:0] a, input logic [4:0] tgt, input int n);
    logic [4:0] cur;
    int         k;
    host.wr(8'h05, cfg);
    cur = code(a);
    host.wr(a, {3'h0, tgt});
    for (int s = 0; s < 32 && cur !== tgt; s++)
    begin
      k = 0;
      while (code(a) === cur && k < n + 10)
      begin
        @(posedge clk_i);
        #1;
        k++;
      end
      `CHK("ramp code", (tgt > cur) ? cur + 5'h01 : cur - 5'h01, code(a))
      `CHK("ramp gap", 1'b1, k >= n - 2 && k <= n + 4)
      cur = code(a);
    end
    `CHK("ramp end", tgt, code(a))
  endtask

  // ********
  // Main sequence and hang guard
  // ********
  initial
  begin
    do_reset();
    t_reset_vals();
    t_rw_all();
    t_pins();
    t_ramp(8'h70, 8'h04, 5'h07, 78);
    t_ramp(8'h76, 8'h02, 5'h11, 156);
    t_ramp(8'h50, 8'h04, 5'h08, 312);
    t_ramp(8'h04, 8'h02, 5'h12, 625);
    do_reset();
    t_reset_vals();
    end_sim();
  end

  // Whole run needs about 1600 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
endmodule
